// ===== logic/charge_seq_pkg.sv
package charge_seq_pkg;

  // ---------------------------------------------------------------
  // clock and timing constants
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_NS     = 40;              // 25 MHz core clock
  localparam longint unsigned NS_PER_S          = 1_000_000_000;
  localparam longint unsigned PRECOND_TIME_MIN  = 60;              // preconditioning timeout, minutes
  localparam longint unsigned PRECOND_CYCLES    = (PRECOND_TIME_MIN * 60 * NS_PER_S) / CLK_PERIOD_NS;
  localparam longint unsigned BLINK_FREQ_HZ     = 2;               // fault flash rate
  localparam longint unsigned BLINK_HALF_CYCLES = NS_PER_S / (CLK_PERIOD_NS * BLINK_FREQ_HZ * 2);
  localparam int              TIMER_WIDTH       = 40;              // holds PRECOND_CYCLES
  localparam int              BLINK_WIDTH       = 24;              // holds BLINK_HALF_CYCLES

  // ---------------------------------------------------------------
  // current programming constants
  // ---------------------------------------------------------------
  localparam int              CURRENT_WIDTH     = 16;              // milliamperes
  localparam int              RES_WIDTH         = 8;               // kilo-ohms
  localparam logic [15:0]     CUR_K_LOW         = 16'h00c8;        // 200 mA*kohm, low-current variant
  localparam logic [15:0]     CUR_K_STD         = 16'h03e8;        // 1000 mA*kohm, standard variant
  localparam logic [15:0]     PRECOND_DIVISOR   = 16'h000a;        // one tenth of fast current
  localparam logic [15:0]     CURRENT_RESET     = 16'h0000;

  // ---------------------------------------------------------------
  // charge phases, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_SHUTDOWN   = 6'h01,  // supply not qualified
    ST_STANDBY    = 6'h02,  // disabled, no battery, or overcharge hold
    ST_PRECOND    = 6'h04,  // reduced current on a deep-discharged cell
    ST_FAST       = 6'h08,  // constant_current_phase
    ST_CONST_VOLT = 6'h10,  // regulation_voltage reached
    ST_FAULT      = 6'h20   // preconditioning timer expired
  } state_type;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic supply_above_lockout;  // supply above undervoltage_lockout level
    logic supply_qualified;      // supply about 150 mV above battery
    logic supply_near_battery;   // supply within 50 mV of battery
    logic batt_present;          // battery node below battery_detect_threshold
    logic batt_below_start;      // battery below 96.5% of regulation_voltage
    logic batt_below_precond;    // battery below preconditioning threshold
    logic batt_at_regulation;    // battery reached regulation_voltage
    logic batt_over_hysteresis;  // battery above regulation_voltage plus hysteresis
    logic disable_pin;           // active-high disable, pulled down outside
  } sense_type;

  typedef struct packed {
    logic out;                   // level driven while enabled, always low
    logic oe;                    // high while the pin is pulled low
  } status_pin_type;

endpackage

// ===== logic/sense_sync.sv
`timescale 1ns/10ps
module sense_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] synced
);

  // ---------------------------------------------------------------
  // two-flop synchroniser state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;   // first stage, read only by second
    logic [WIDTH-1:0] sync;   // second stage
  } sync_state_type;

  sync_state_type r;          // registered state
  sync_state_type next_r;     // next value

  // per-bit chain, first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_r.meta[i] = raw[i];
        next_r.sync[i] = r.meta[i];
      end
    end
  endgenerate

  // register, frozen while clock enable is low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign synced = r.sync;

endmodule

// ===== logic/phase_timer.sv
`timescale 1ns/10ps
module phase_timer #(
  parameter int                      WIDTH = 40,
  parameter logic [WIDTH-1:0]        LIMIT = '1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             clear,
  input  wire logic             run,
  output logic      [WIDTH-1:0] count,
  output logic                  expired
);

  // ---------------------------------------------------------------
  // saturating counter state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] count;  // cycles since last clear
  } timer_state_type;

  timer_state_type r;         // registered state
  timer_state_type next_r;    // next value

  // expiry after LIMIT-1 counted cycles; saturates so it stays expired
  assign expired = (r.count == LIMIT - WIDTH'(1));

  // clear wins over counting
  always_comb begin
    next_r = r;
    if (clear) begin
      next_r.count = '0;
    end else if (run && !expired) begin
      next_r.count = r.count + WIDTH'(1);
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign count = r.count;

endmodule

// ===== logic/li_ion_charge_sequencer.sv
`timescale 1ns/10ps
module li_ion_charge_sequencer #(
  parameter bit                           LOW_CURRENT_VARIANT    = 1'b0,
  parameter bit                           HAS_PRECOND            = 1'b1,
  parameter bit                           HAS_PRECOND_TIMER      = 1'b1,
  parameter int                           RES_WIDTH              = charge_seq_pkg::RES_WIDTH,
  parameter logic [charge_seq_pkg::TIMER_WIDTH-1:0] PRECOND_TIMEOUT_CYCLES =
    charge_seq_pkg::TIMER_WIDTH'(charge_seq_pkg::PRECOND_CYCLES),
  parameter logic [charge_seq_pkg::BLINK_WIDTH-1:0] BLINK_HALF_CYCLES =
    charge_seq_pkg::BLINK_WIDTH'(charge_seq_pkg::BLINK_HALF_CYCLES)
) (
  input  wire logic                                      clk,
  input  wire logic                                      resetn,
  input  wire logic                                      clk_en,
  input  wire charge_seq_pkg::sense_type                 sense,
  input  wire logic [RES_WIDTH-1:0]                      current_set_resistor,
  output charge_seq_pkg::status_pin_type                 status_pin,
  output logic [charge_seq_pkg::CURRENT_WIDTH-1:0]       charge_current_ma,
  output charge_seq_pkg::state_type                      state,
  output logic                                           timer_fault
);

  // ---------------------------------------------------------------
  // local widths
  // ---------------------------------------------------------------
  localparam int CW = charge_seq_pkg::CURRENT_WIDTH;  // current word
  localparam int TW = charge_seq_pkg::TIMER_WIDTH;    // phase timer
  localparam int BW = charge_seq_pkg::BLINK_WIDTH;    // blink timer

  // ---------------------------------------------------------------
  // block state
  // ---------------------------------------------------------------
  typedef struct packed {
    charge_seq_pkg::state_type state;      // charge phase
    logic [CW-1:0]             current;    // commanded current, mA
    logic                      status_oe;  // status pin pulled low
    logic                      blink;      // flash phase during fault
  } seq_state_type;

  seq_state_type r;                        // registered state
  seq_state_type next_r;                   // next value

  charge_seq_pkg::sense_type s;            // synchronised comparators
  logic                      supply_ok;    // supply fit to run
  logic                      start_ok;     // charge may begin
  logic [CW-1:0]             fast_current; // programmed current
  logic [CW-1:0]             k_const;      // variant constant
  logic                      phase_clear;  // restart phase timer on entry
  logic                      phase_run;    // preconditioning timing
  logic                      phase_expired;
  logic [TW-1:0]             phase_count;
  logic                      blink_expired;
  logic                      blink_clear;
  logic                      precond_timeout;

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------

  // comparators are asynchronous to the core clock
  sense_sync #(
    .WIDTH ($bits(charge_seq_pkg::sense_type))
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .raw    (sense),
    .synced (s)
  );

  // ---------------------------------------------------------------
  // qualification
  // ---------------------------------------------------------------

  // lockout and power-down checks run in every state
  always_comb begin
    supply_ok = s.supply_above_lockout && s.supply_qualified
                && !s.supply_near_battery;
    start_ok  = supply_ok && !s.disable_pin
                && s.batt_present
                && s.batt_below_start
                && !s.batt_over_hysteresis;
  end

  // ---------------------------------------------------------------
  // current programming
  // ---------------------------------------------------------------

  // a shorted resistor would divide by zero; clamp to full scale
  always_comb begin
    k_const = LOW_CURRENT_VARIANT ? charge_seq_pkg::CUR_K_LOW : charge_seq_pkg::CUR_K_STD;
    if (current_set_resistor == '0) begin
      fast_current = k_const;
    end else begin
      fast_current = k_const / CW'(current_set_resistor);
    end
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------

  // any phase change restarts timing, including entry to fast charge
  assign phase_clear = (next_r.state != r.state);
  assign phase_run   = HAS_PRECOND_TIMER && (r.state == charge_seq_pkg::ST_PRECOND);
  assign precond_timeout = HAS_PRECOND_TIMER && phase_expired;

  phase_timer #(
    .WIDTH (TW),
    .LIMIT (PRECOND_TIMEOUT_CYCLES)
  ) u_phase_timer (
    .clk     (clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .clear   (phase_clear),
    .run     (phase_run),
    .count   (phase_count),
    .expired (phase_expired)
  );

  // blink timer free-runs only inside the fault phase
  assign blink_clear = (r.state != charge_seq_pkg::ST_FAULT) || blink_expired;

  phase_timer #(
    .WIDTH (BW),
    .LIMIT (BLINK_HALF_CYCLES)
  ) u_blink_timer (
    .clk     (clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .clear   (blink_clear),
    .run     (1'b1),
    .count   (),
    .expired (blink_expired)
  );

  // ---------------------------------------------------------------
  // phase sequencing
  // ---------------------------------------------------------------

  always_comb begin
    next_r = r;
    // supply loss overrides everything and clears a fault
    if (!supply_ok) begin
      next_r.state = charge_seq_pkg::ST_SHUTDOWN;
    end else if (s.disable_pin) begin
      next_r.state = charge_seq_pkg::ST_STANDBY;
    end else begin
      case (r.state)
        charge_seq_pkg::ST_SHUTDOWN,
        charge_seq_pkg::ST_STANDBY: begin
          // idle until a cell is seen and may be charged
          if (start_ok) begin
            if (HAS_PRECOND && s.batt_below_precond) begin
              next_r.state = charge_seq_pkg::ST_PRECOND;
            end else begin
              next_r.state = charge_seq_pkg::ST_FAST;
            end
          end else begin
            next_r.state = charge_seq_pkg::ST_STANDBY;
          end
        end
        charge_seq_pkg::ST_PRECOND: begin
          // threshold crossing beats a timeout in the same cycle
          if (s.batt_over_hysteresis) begin
            next_r.state = charge_seq_pkg::ST_STANDBY;
          end else if (!s.batt_below_precond) begin
            next_r.state = charge_seq_pkg::ST_FAST;
          end else if (precond_timeout) begin
            next_r.state = charge_seq_pkg::ST_FAULT;
          end
        end
        charge_seq_pkg::ST_FAST: begin
          if (s.batt_over_hysteresis) begin
            next_r.state = charge_seq_pkg::ST_STANDBY;
          end else if (s.batt_at_regulation) begin
            next_r.state = charge_seq_pkg::ST_CONST_VOLT;
          end
        end
        charge_seq_pkg::ST_CONST_VOLT: begin
          // termination lives in the analog loop; only overcharge exits here
          if (s.batt_over_hysteresis) begin
            next_r.state = charge_seq_pkg::ST_STANDBY;
          end
        end
        charge_seq_pkg::ST_FAULT: begin
          // latched; only battery removal leaves it from here
          if (!s.batt_present) begin
            next_r.state = charge_seq_pkg::ST_STANDBY;
          end else begin
            next_r.state = charge_seq_pkg::ST_FAULT;
          end
        end
        default: begin
          next_r.state = charge_seq_pkg::ST_SHUTDOWN;
        end
      endcase
    end

    // blink phase toggles every half period while faulted
    if (next_r.state != charge_seq_pkg::ST_FAULT) begin
      next_r.blink = 1'b0;
    end else if (blink_expired) begin
      next_r.blink = !r.blink;
    end

    // outputs follow the next phase so they align with state
    case (next_r.state)
      charge_seq_pkg::ST_PRECOND: begin
        next_r.current   = fast_current / charge_seq_pkg::PRECOND_DIVISOR;
        next_r.status_oe = 1'b1;
      end
      charge_seq_pkg::ST_FAST: begin
        next_r.current   = fast_current;
        next_r.status_oe = 1'b1;
      end
      charge_seq_pkg::ST_CONST_VOLT: begin
        next_r.current   = fast_current;  // upper limit; loop tapers it
        next_r.status_oe = 1'b1;
      end
      charge_seq_pkg::ST_FAULT: begin
        next_r.current   = charge_seq_pkg::CURRENT_RESET;
        next_r.status_oe = next_r.blink;
      end
      default: begin
        next_r.current   = charge_seq_pkg::CURRENT_RESET;
        next_r.status_oe = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------

  // synchronous reset; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r.state   <= charge_seq_pkg::ST_SHUTDOWN;
      r.current <= charge_seq_pkg::CURRENT_RESET;
      r.status_oe <= 1'b0;
      r.blink   <= 1'b0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // open drain: only ever drives low, else released
  assign status_pin.out    = 1'b0;
  assign status_pin.oe     = r.status_oe;
  assign charge_current_ma = r.current;
  assign state             = r.state;
  assign timer_fault       = (r.state == charge_seq_pkg::ST_FAULT);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_lockout;
    clk_en && !(s.supply_above_lockout && s.supply_qualified) |=> state == charge_seq_pkg::ST_SHUTDOWN;
  endproperty
  a_lockout: assert property (p_lockout) else $error("no shutdown on supply lockout");

  property p_power_down;
    clk_en && s.supply_near_battery |=> state == charge_seq_pkg::ST_SHUTDOWN && charge_current_ma == '0;
  endproperty
  a_power_down: assert property (p_power_down) else $error("no power-down near battery");

  property p_start_qualified;
    (state inside {charge_seq_pkg::ST_STANDBY, charge_seq_pkg::ST_SHUTDOWN})
      ##1 (state inside {charge_seq_pkg::ST_PRECOND, charge_seq_pkg::ST_FAST})
      |-> $past(start_ok);
  endproperty
  a_start_qualified: assert property (p_start_qualified) else $error("charge began unqualified");

  property p_disable;
    clk_en && supply_ok && s.disable_pin |=> state == charge_seq_pkg::ST_STANDBY && !status_pin.oe;
  endproperty
  a_disable: assert property (p_disable) else $error("disable pin not obeyed");

  property p_overcharge;
    clk_en && supply_ok && !s.disable_pin && s.batt_over_hysteresis
      && (state inside {charge_seq_pkg::ST_PRECOND, charge_seq_pkg::ST_FAST, charge_seq_pkg::ST_CONST_VOLT})
      |=> state == charge_seq_pkg::ST_STANDBY;
  endproperty
  a_overcharge: assert property (p_overcharge) else $error("charge not suspended on overcharge");

  property p_precond_current;
    state == charge_seq_pkg::ST_PRECOND |-> charge_current_ma == fast_current / charge_seq_pkg::PRECOND_DIVISOR;
  endproperty
  a_precond_current: assert property (p_precond_current) else $error("preconditioning current wrong");

  property p_precond_exit;
    clk_en && supply_ok && !s.disable_pin && !s.batt_over_hysteresis && !s.batt_below_precond
      && state == charge_seq_pkg::ST_PRECOND |=> state == charge_seq_pkg::ST_FAST;
  endproperty
  a_precond_exit: assert property (p_precond_exit) else $error("no move to fast charge");

  property p_timeout_fault;
    clk_en && supply_ok && !s.disable_pin && !s.batt_over_hysteresis && s.batt_below_precond
      && state == charge_seq_pkg::ST_PRECOND && precond_timeout |=> timer_fault && charge_current_ma == '0;
  endproperty
  a_timeout_fault: assert property (p_timeout_fault) else $error("timeout did not fault");

  property p_fault_latched;
    timer_fault && clk_en && supply_ok && !s.disable_pin && s.batt_present |=> timer_fault;
  endproperty
  a_fault_latched: assert property (p_fault_latched) else $error("fault released early");

  property p_fault_removal;
    timer_fault && clk_en && supply_ok && !s.disable_pin && !s.batt_present
      |=> state == charge_seq_pkg::ST_STANDBY;
  endproperty
  a_fault_removal: assert property (p_fault_removal) else $error("removal did not give standby");

  property p_no_timer_no_fault;
    !HAS_PRECOND_TIMER |-> !timer_fault;
  endproperty
  a_no_timer_no_fault: assert property (p_no_timer_no_fault) else $error("fault without timer");

  property p_fast_current;
    state == charge_seq_pkg::ST_FAST |-> charge_current_ma == fast_current && status_pin.oe;
  endproperty
  a_fast_current: assert property (p_fast_current) else $error("fast current wrong");

  property p_timer_restart;
    $rose(state == charge_seq_pkg::ST_FAST) |-> phase_count == '0;
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

  property p_status_idle;
    (state inside {charge_seq_pkg::ST_SHUTDOWN, charge_seq_pkg::ST_STANDBY}) |-> !status_pin.oe && !status_pin.out;
  endproperty
  a_status_idle: assert property (p_status_idle) else $error("status driven while idle");

  c_fault:     cover property (state == charge_seq_pkg::ST_PRECOND ##1 timer_fault);
  c_to_fast:   cover property (state == charge_seq_pkg::ST_PRECOND ##1 state == charge_seq_pkg::ST_FAST);
  c_to_cv:     cover property (state == charge_seq_pkg::ST_FAST ##1 state == charge_seq_pkg::ST_CONST_VOLT);
  c_blink:     cover property (timer_fault && $fell(status_pin.oe));

endmodule

// ===== sim/cell_load.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// far side: status pull-up and disable pin
// ---------------------------------------------------------------
module cell_load (
  input  wire charge_seq_pkg::status_pin_type status_pin,
  input  wire logic                           dis_drive,
  input  wire logic                           dis_float,
  output logic                                stat_level,
  output logic                                dis_level
);
  // pull-up reads a released pin high
  assign stat_level = status_pin.oe ? status_pin.out : 1'b1;
  // pull-down keeps the charger enabled while floating
  assign dis_level = dis_float ? 1'b0 : dis_drive;
endmodule

// ===== sim/li_ion_charge_sequencer_bench.sv
`timescale 1ns/10ps
module li_ion_charge_sequencer_bench;
  logic                      clk, clk_en, resetn, dis_drive, dis_float, stat_level, dis_level, timer_fault;
  logic [8:1]                sense_raw;  // sense bits above the disable pin
  charge_seq_pkg::status_pin_type status_pin;
  logic [15:0]               current;
  charge_seq_pkg::state_type state;
  int                        n_fail, tests_run, i;
  // short timer and blink so the fault path fits the run
  li_ion_charge_sequencer #(.PRECOND_TIMEOUT_CYCLES(40'h32), .BLINK_HALF_CYCLES(24'h8)) dut (
    .clk(clk), .resetn(resetn), .clk_en(clk_en),
    .sense(charge_seq_pkg::sense_type'({sense_raw, dis_level})), .current_set_resistor(8'h0a),
    .status_pin(status_pin), .charge_current_ma(current), .state(state), .timer_fault(timer_fault));
  cell_load load (.status_pin(status_pin), .dis_drive(dis_drive), .dis_float(dis_float),
    .stat_level(stat_level), .dis_level(dis_level));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk_state(input charge_seq_pkg::state_type exp);
    tests_run++;
    if (state !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, state);
    end
  endtask
  task chk_val(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // sync 2 plus state 1 edges, one spare
  task apply(input logic [8:1] s);
    @(posedge clk);
    #1 sense_raw = s;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // bounded wait for a status pin level
  task wait_stat(input logic lvl);
    for (i = 0; i < 30 && stat_level !== lvl; i++) @(posedge clk) #1;
    chk_val({15'h0, lvl}, {15'h0, stat_level});
    if (stat_level !== lvl) summarize();
  endtask
  task t_charge;
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_PRECOND);
    chk_val(16'h000a, current);
    chk_val(16'h0000, {15'h0, stat_level});
    apply(8'hd8);
    chk_state(charge_seq_pkg::ST_FAST);
    chk_val(16'h0064, current);
    apply(8'hda);
    chk_state(charge_seq_pkg::ST_CONST_VOLT);
    apply(8'hd9);
    chk_state(charge_seq_pkg::ST_STANDBY);
    chk_val(16'h0001, {15'h0, stat_level});
    $display("charge path done");
  endtask
  task t_supply;
    apply(8'hdc);
    dis_drive = 1'b1;
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_STANDBY);
    dis_drive = 1'b0;
    apply(8'h9c);
    chk_state(charge_seq_pkg::ST_SHUTDOWN);
    apply(8'hdc);
    apply(8'hf8);
    chk_state(charge_seq_pkg::ST_SHUTDOWN);
    chk_val(16'h0000, current);
    $display("supply path done");
  endtask
  task t_fault;
    apply(8'hdc);
    for (i = 0; i < 200 && timer_fault !== 1'b1; i++) @(posedge clk) #1;
    chk_val(16'h0001, {15'h0, timer_fault});
    if (timer_fault !== 1'b1) summarize();
    chk_val(16'h0001, 16'(i >= 40 && i <= 60));
    wait_stat(1'b0);
    wait_stat(1'b1);
    chk_val(16'h0008, 16'(i));
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_FAULT);
    apply(8'hcc);
    chk_state(charge_seq_pkg::ST_STANDBY);
    $display("fault path done");
  endtask
  // refusals, fault cleared by disable, clock-enable freeze, reset in mid-run
  task t_recover;
    apply(8'hd0);
    chk_state(charge_seq_pkg::ST_STANDBY);
    apply(8'hdd);
    chk_state(charge_seq_pkg::ST_STANDBY);
    apply(8'h5c);
    chk_state(charge_seq_pkg::ST_SHUTDOWN);
    apply(8'hdc);
    for (i = 0; i < 80 && timer_fault !== 1'b1; i++) @(posedge clk) #1;
    chk_val(16'h0001, {15'h0, timer_fault});
    if (timer_fault !== 1'b1) summarize();
    // floating pin reads low through the pull-down, so the fault stays
    {dis_float, dis_drive} = 2'b11;
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_FAULT);
    dis_float = 1'b0;
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_STANDBY);
    chk_val(16'h0001, {15'h0, stat_level});
    dis_drive = 1'b0;
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_PRECOND);
    // enable low: a supply loss must not be seen yet
    clk_en = 1'b0;
    apply(8'h5c);
    chk_state(charge_seq_pkg::ST_PRECOND);
    clk_en = 1'b1;
    apply(8'h5c);
    chk_state(charge_seq_pkg::ST_SHUTDOWN);
    apply(8'hdc);
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_state(charge_seq_pkg::ST_SHUTDOWN);
    chk_val(16'h0001, {15'h0, stat_level});
    resetn = 1'b1;
    apply(8'hdc);
    chk_state(charge_seq_pkg::ST_PRECOND);
    $display("recovery path done");
  endtask
  initial begin
    {resetn, dis_drive, dis_float, n_fail, tests_run} = '0;
    sense_raw = 8'h00;
    clk_en = 1'b1;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    t_charge();
    t_supply();
    t_fault();
    t_recover();
    summarize();
  end
endmodule
